// ### logic/dioc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    dioc_phase_if.src ph
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // The first stage feeds only the second, so a metastable sample never reaches logic.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign ph.cur = sync_q;
    assign ph.prev = prev_q;
endmodule
`default_nettype wire

// ### logic/dioc_top.sv
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dioc_params.svh"

// Function
// - Two ports of 16 two-way lines each, with direction chosen by software per group of eight.
// - After reset every line of port A is an input and every line of port B an output.
// - In count mode a 32-bit counter adds one for each rising edge sampled on the selected phase A line.
// - Counting past all ones returns the counter to zero and counting goes on upward.
// - When the external reset line is assigned, holding it high keeps the counter at zero.
// - In encoder mode phase B is decoded against phase A to count up or down.
// - Phase A, phase B and reset are each mapped by software onto any of the 32 lines.
module dioc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] io_in_i,
    output logic [31:0] io_out_o,
    output logic [31:0] io_oe_o
);
    logic [31:0] out_q;
    logic [31:0] oe_q;
    logic [31:0] cfg_q;
    logic [31:0] func_q;
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic wr_en;
    logic [31:0] wmask;
    logic [3:0] dir_bits;
    dioc_pkg::dioc_line_t sel_a;
    dioc_pkg::dioc_line_t sel_b;
    dioc_pkg::dioc_line_t sel_r;
    dioc_pkg::dioc_mode_e mode;
    logic raw_a;
    logic raw_b;
    logic raw_r;
    logic hit_out_a;
    logic hit_out_b;
    logic hit_dir;
    logic hit_cfg;
    logic hit_func;
    logic a_rise;
    logic a_step;
    logic b_step;
    logic enc_up;

    // Reset direction per group, 1 = output, so port B drives from the start.
    localparam logic [3:0] dir_rst_c = `DIOC_DIR_RESET;

    dioc_phase_if ph_a ();
    dioc_phase_if ph_b ();
    dioc_phase_if ph_r ();

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign hit_out_a = wr_en && wb_adr_i == `DIOC_OFS_OUT_A;
    assign hit_out_b = wr_en && wb_adr_i == `DIOC_OFS_OUT_B;
    assign hit_dir = wr_en && wb_adr_i == `DIOC_OFS_DIR && wb_sel_i[0];
    assign hit_cfg = wr_en && wb_adr_i == `DIOC_OFS_CNT_CFG;
    assign hit_func = wr_en && wb_adr_i == `DIOC_OFS_CNT_FUNC;

    // Bus slave: every access, mapped or not, is answered one cycle after it is presented.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    // Read data is registered so that it stands together with the one-cycle acknowledge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= 32'h0000_0000;
        end else if (hit_out_a) begin
            out_q[15:0] <= (out_q[15:0] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end else if (hit_out_b) begin
            out_q[31:16] <= (out_q[31:16] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
        end
    end

    // Each enable byte copies one direction bit, so a single line can never differ from its group.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int g = 0; g < `DIOC_GROUPS; g++) begin
                oe_q[g*`DIOC_GROUP +: `DIOC_GROUP] <= {`DIOC_GROUP{dir_rst_c[g]}};
            end
        end else if (hit_dir) begin
            for (int g = 0; g < `DIOC_GROUPS; g++) begin
                oe_q[g*`DIOC_GROUP +: `DIOC_GROUP] <= {`DIOC_GROUP{wb_dat_i[g]}};
            end
        end
    end

    assign dir_bits = {oe_q[24], oe_q[16], oe_q[8], oe_q[0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= 32'h0000_0000;
        end else if (hit_cfg) begin
            cfg_q <= ((cfg_q & ~wmask) | (wb_dat_i & wmask)) & (`DIOC_CFG_MASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            func_q <= 32'h0000_0000;
        end else if (hit_func) begin
            func_q <= (func_q & ~wmask) | (wb_dat_i & wmask);
        end
    end

    always_comb begin
        case (wb_adr_i)
            `DIOC_OFS_OUT_A: rdat_d = {16'h0000, out_q[15:0]};
            `DIOC_OFS_OUT_B: rdat_d = {16'h0000, out_q[31:16]};
            `DIOC_OFS_DIR: rdat_d = {28'h000_0000, dir_bits};
            `DIOC_OFS_PIN_IN: rdat_d = io_in_i;
            `DIOC_OFS_CNT_CFG: rdat_d = cfg_q;
            `DIOC_OFS_CNT_FUNC: rdat_d = func_q;
            `DIOC_OFS_COUNT: rdat_d = count_q;
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    assign sel_a = cfg_q[`DIOC_CFG_SEL_A_LSB +: `DIOC_CFG_SEL_W];
    assign sel_b = cfg_q[`DIOC_CFG_SEL_B_LSB +: `DIOC_CFG_SEL_W];
    assign sel_r = cfg_q[`DIOC_CFG_SEL_R_LSB +: `DIOC_CFG_SEL_W];
    assign mode = dioc_pkg::dioc_mode_e'(cfg_q[`DIOC_CFG_MODE_BIT]);

    // A line not marked for counter operation reads as low to the counter.
    assign raw_a = io_in_i[sel_a] & func_q[sel_a];
    assign raw_b = io_in_i[sel_b] & func_q[sel_b];
    assign raw_r = io_in_i[sel_r] & func_q[sel_r] & cfg_q[`DIOC_CFG_RST_EN_BIT];

    dioc_sync u_sync_a (.clk_i(clk_i), .rst_i(rst_i), .raw_i(raw_a), .ph(ph_a));
    dioc_sync u_sync_b (.clk_i(clk_i), .rst_i(rst_i), .raw_i(raw_b), .ph(ph_b));
    dioc_sync u_sync_r (.clk_i(clk_i), .rst_i(rst_i), .raw_i(raw_r), .ph(ph_r));

    assign a_rise = ph_a.cur && !ph_a.prev;
    assign a_step = ph_a.cur ^ ph_a.prev;
    assign b_step = ph_b.cur ^ ph_b.prev;
    assign enc_up = ph_a.cur ^ ph_b.prev;

    // Sampling at the system clock limits the real rate to well under half of it;
    // faster pulses are undercounted, which is the price of a single clock domain.
    always_comb begin
        count_d = count_q;
        case (mode)
            dioc_pkg::DIOC_MODE_COUNT: begin
                if (a_rise) begin
                    count_d = count_q + 32'h0000_0001;
                end
            end
            dioc_pkg::DIOC_MODE_ENCODER: begin
                // Four counts per cycle; a step where both phases move at once is ignored.
                if (a_step != b_step) begin
                    if (enc_up) begin
                        count_d = count_q + 32'h0000_0001;
                    end else begin
                        count_d = count_q - 32'h0000_0001;
                    end
                end
            end
            default: count_d = count_q;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= `DIOC_COUNT_RESET;
        end else if (ph_r.cur) begin
            count_q <= `DIOC_COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // The port never drives a line whose group is an input, which protects counter sources.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_out_o <= 32'h0000_0000;
        end else begin
            io_out_o <= out_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_oe_o <= 32'h0000_0000;
        end else begin
            io_oe_o <= oe_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule
`default_nettype wire

// ### pkg/dioc_params.svh
`ifndef DIOC_PARAMS_SVH
`define DIOC_PARAMS_SVH

// Word-aligned byte offsets on the register bus.
`define DIOC_OFS_OUT_A 8'h00
`define DIOC_OFS_OUT_B 8'h04
`define DIOC_OFS_DIR 8'h08
`define DIOC_OFS_PIN_IN 8'h0C
`define DIOC_OFS_CNT_CFG 8'h10
`define DIOC_OFS_CNT_FUNC 8'h14
`define DIOC_OFS_COUNT 8'h18

// Line layout: port A on lines 0..15, port B on lines 16..31.
`define DIOC_LINES 32
`define DIOC_GROUP 8
`define DIOC_GROUPS 4

// Direction register reset value, one bit per group, 1 = output.
`define DIOC_DIR_RESET 4'hC

// Counter configuration fields.
`define DIOC_CFG_SEL_A_LSB 0
`define DIOC_CFG_SEL_B_LSB 8
`define DIOC_CFG_SEL_R_LSB 16
`define DIOC_CFG_SEL_W 5
`define DIOC_CFG_MODE_BIT 24
`define DIOC_CFG_RST_EN_BIT 25
`define DIOC_CFG_MASK 32'h031F_1F1F

`define DIOC_COUNT_RESET 32'h0000_0000

// Highest documented pulse rates in kHz, set against the 10 MHz clock.
`define DIOC_CLK_KHZ 10000
`define DIOC_COUNT_MAX_KHZ 16000
`define DIOC_ENC_MAX_KHZ 4000

`endif

// ### pkg/dioc_phase_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dioc_phase_if;
    logic cur;
    logic prev;
    modport src (output cur, output prev);
    modport dst (input cur, input prev);
endinterface
`default_nettype wire

// ### pkg/dioc_pkg.sv
`default_nettype none
package dioc_pkg;
    typedef enum logic {
        DIOC_MODE_COUNT,
        DIOC_MODE_ENCODER
    } dioc_mode_e;

    typedef logic [4:0] dioc_line_t;
endpackage
`default_nettype wire

// ### tb/dioc_ext.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_ext (
    input wire logic [31:0] ext_i,
    input wire logic [31:0] out_i,
    input wire logic [31:0] oe_i,
    output logic [31:0] line_o
);
    // A line the block drives shows its level, so sources only reach input groups.
    assign line_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ### tb/dioc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [31:0] io_in_i,
    input wire logic [31:0] io_out_o,
    input wire logic [31:0] io_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(logic [7:0] a);
        s_take ##0 (wb_we_i && wb_adr_i == a && wb_sel_i == 4'hF);
    endsequence
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_req; s_take |=> wb_ack_o; endproperty
    a_ack_req: assert property (p_ack_req) else $error("request not answered");
    property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_oe_grp;
        io_oe_o == {{8{io_oe_o[24]}}, {8{io_oe_o[16]}}, {8{io_oe_o[8]}}, {8{io_oe_o[0]}}};
    endproperty
    a_oe_grp: assert property (p_oe_grp) else $error("direction split in a group");
    property p_rst_dir; $fell(rst_i) |-> ##[0:1] io_oe_o == 32'hFFFF_0000; endproperty
    a_rst_dir: assert property (p_rst_dir) else $error("bad direction after reset");
    property p_dir_wr;
        s_wr(8'h08) ##0 wb_dat_i[3:0] == 4'h5 |-> ##2 io_oe_o == 32'h00FF_00FF;
    endproperty
    a_dir_wr: assert property (p_dir_wr) else $error("direction write not applied");
    property p_out_b; s_wr(8'h04) |-> ##2 io_out_o[31:16] == $past(wb_dat_i[15:0], 2); endproperty
    a_out_b: assert property (p_out_b) else $error("port B level wrong");
    property p_pin; s_take ##0 (!wb_we_i && wb_adr_i == 8'h0C) |=> wb_dat_o == $past(io_in_i);
    endproperty
    a_pin: assert property (p_pin) else $error("line read wrong");
endmodule
bind dioc_top dioc_top_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_in_i(io_in_i),
    .io_out_o(io_out_o), .io_oe_o(io_oe_o));
`default_nettype wire

// ### tb/dioc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dioc_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] ext_q = 32'h0000_0000;
    logic [3:0] sel = 4'hF;
    logic [3:0] bsel = 4'hF;
    logic [31:0] dat_o, io_in, io_out, io_oe, rd;
    logic ack;
    int fails = 0;
    int n_tests = 0;
    dioc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .io_in_i(io_in), .io_out_o(io_out), .io_oe_o(io_oe));
    dioc_ext ext (.ext_i(ext_q), .out_i(io_out), .oe_i(io_oe), .line_o(io_in));
    initial forever #50 clk_i = ~clk_i;
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= bsel;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (ack !== 1'b1 && i < 20);
        rd = dat_o;
        cyc <= 1'b0;
        if (i >= 20) begin
            fails++;
            stop_test();
        end
    endtask
    task line(input int n, input logic v);
        @(posedge clk_i);
        ext_q[n] <= v;
        repeat (4) @(posedge clk_i);
    endtask
    task t_ports;
        @(posedge clk_i);
        ext_q <= 32'h1234_5678;
        wb(1'b1, 8'h04, 32'h0000_A5C3);
        wb(1'b1, 8'h08, 32'h0000_0005);
        bsel = 4'h1;
        wb(1'b1, 8'h00, 32'h0000_BE3C);
        bsel = 4'h2;
        wb(1'b1, 8'h08, 32'h0000_000F);
        bsel = 4'hF;
        repeat (2) @(posedge clk_i);
        chk(io_out, 32'hA5C3_003C);
        chk(io_oe, 32'h00FF_00FF);
        wb(1'b0, 8'h0C, 32'h0000_0000);
        chk(rd, 32'h12C3_563C);
        wb(1'b0, 8'h08, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        wb(1'b0, 8'h00, 32'h0000_0000);
        chk(rd, 32'h0000_003C);
        wb(1'b1, 8'h08, 32'h0000_0000);
        @(posedge clk_i);
        ext_q <= 32'h0000_0000;
    endtask
    task t_count;
        wb(1'b1, 8'h10, 32'h0000_0014);
        wb(1'b1, 8'h14, 32'h0010_0000);
        repeat (5) begin
            line(20, 1'b1);
            line(20, 1'b0);
        end
        line(3, 1'b1);
        line(3, 1'b0);
        wb(1'b0, 8'h18, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
    endtask
    task t_encoder;
        wb(1'b1, 8'h14, 32'h0000_0086);
        wb(1'b1, 8'h10, 32'h0207_0001);
        line(7, 1'b1);
        line(1, 1'b1);
        line(1, 1'b0);
        wb(1'b0, 8'h18, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        line(7, 1'b0);
        wb(1'b1, 8'h10, 32'h0100_0201);
        line(2, 1'b1);
        wb(1'b0, 8'h18, 32'h0000_0000);
        chk(rd, 32'hFFFF_FFFF);
        line(2, 1'b0);
        wb(1'b0, 8'h18, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        line(1, 1'b1);
        line(2, 1'b1);
        line(1, 1'b0);
        line(2, 1'b0);
        wb(1'b0, 8'h18, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(io_oe, 32'hFFFF_0000);
        wb(1'b0, 8'h08, 32'h0000_0000);
        chk(rd, 32'h0000_000C);
        t_ports();
        t_count();
        t_encoder();
        stop_test();
    end
endmodule
`default_nettype wire
